// ---- pkg/rio_pkg.sv ----
// Purpose: Shared constants, types and helpers for the remote I/O link ends.
// Assumes: 125 MHz ref_clk; async UART-style frames on the serial link.
// Notes:   One byte on the CPU side covers eight consecutive I/O points.
`default_nettype none
package rio_pkg;
    localparam int          CLK_HZ       = 125_000_000;
    localparam int          CNT_W        = 21;
    localparam int          SW_W         = 7;
    localparam int          MAX_BYTES    = 32;
    localparam int          BYTES_120    = 16;
    localparam int          BYTES_248    = 32;
    localparam logic [6:0]  GRP_LAST     = 7'h7c;
    localparam logic [7:0]  SYNC_BYTE    = 8'ha5;
    localparam logic [11:0] TIMEOUT_BITS = 12'h800;
    localparam int          ST_FRESH     = 0;
    localparam int          ST_RPAR      = 3;
    localparam int          ST_ROK       = 4;
    localparam int          ST_LINK      = 5;
    localparam int          ST_LOCAL     = 6;
    localparam int          ST_BEAT      = 7;
    localparam int          RS_PAR       = 0;
    localparam int          RS_OK        = 1;

    typedef enum logic [2:0] {
        RIO_B110   = 3'h0,
        RIO_B300   = 3'h1,
        RIO_B1200  = 3'h2,
        RIO_B2400  = 3'h3,
        RIO_B9600  = 3'h4,
        RIO_B19200 = 3'h5,
        RIO_B57600 = 3'h6
    } rio_baud_t;

    typedef struct packed {
        logic      mode_248;
        rio_baud_t baud;
        logic      par_en;
        logic      par_odd;
        logic      halt_on_fail;
        logic      halt_on_par;
        logic      hold_last;
    } rio_cfg_t;

    localparam rio_cfg_t CFG_DEF = '{mode_248: 1'b0, baud: RIO_B57600, par_en: 1'b1, par_odd: 1'b1,
                                     halt_on_fail: 1'b1, halt_on_par: 1'b1, hold_last: 1'b0};

    function automatic logic [CNT_W-1:0] baud_div(input int clk_hz, input rio_baud_t b);
        int rate;
        unique case (b)
            RIO_B110:   rate = 110;
            RIO_B300:   rate = 300;
            RIO_B1200:  rate = 1200;
            RIO_B2400:  rate = 2400;
            RIO_B9600:  rate = 9600;
            RIO_B19200: rate = 19200;
            RIO_B57600: rate = 57600;
            default:    rate = 57600;
        endcase
        return CNT_W'(clk_hz / rate);
    endfunction

    function automatic logic [5:0] nbytes(input rio_cfg_t c);
        return c.mode_248 ? 6'(BYTES_248) : 6'(BYTES_120);
    endfunction

    function automatic logic [3:0] nbits(input rio_cfg_t c);
        return c.par_en ? 4'hb : 4'ha;
    endfunction

    // Start, data LSB first, parity, stop; with parity off the parity slot is sent high as the stop
    function automatic logic [10:0] tx_frame(input logic [7:0] d, input rio_cfg_t c);
        logic p;
        p = c.par_en ? (^d ^ c.par_odd) : 1'b1;
        return {1'b1, p, d, 1'b0};
    endfunction

    // Returns {good, data} from the samples of one frame, last sample on top
    function automatic logic [8:0] rx_decode(input logic [10:0] v, input rio_cfg_t c);
        logic [10:0] a;
        logic        ok;
        a  = c.par_en ? v : {1'b1, v[10:1]};
        ok = v[10] & ~a[0] & (~c.par_en | (a[9] == (^a[8:1] ^ c.par_odd)));
        return {ok, a[8:1]};
    endfunction
endpackage
`default_nettype wire

// ---- pkg/rio_link_if.sv ----
// Purpose: Two-wire serial link between driver end and receiver end.
// Assumes: Both lines idle high; each line has a single driver.
// Notes:   No clocking block; both ends sample through their own synchronisers.
`timescale 1ns/1ps
`default_nettype none
interface rio_link_if;
    logic dn; // Driver to receiver serial data
    logic up; // Receiver to driver serial data
    modport drv (output dn, input up);
    modport rcv (input dn, output up);
endinterface
`default_nettype wire

// ---- rtl/rio_driver.sv ----
// Purpose: CPU-side end: buffers CPU output bytes, ships them serially, returns remote inputs and status.
// Assumes: CPU chain signals are on ref_clk; switches, jumpers and the up line are asynchronous pins.
// Notes:   One exchange runs at a time; a slow baud rate simply spans several sweeps.
// Notes on behaviour
// - Block of 128/256 points, eight kept for driver
// - Block chosen by switch segments 5-7 or 6-7
// - Lower segments give each module unique address
// - Remote modules copy the driver's block segments
// - Own reference carries status, its outputs unused
// - Last block stops at point 1000
// - Drivers and input modules need distinct addresses
// - Bit 1 toggles per fresh input delivery
// - Bit 4 low on remote parity error
// - Bit 5 low on remote system fault
// - Bit 6 low on link error
// - Bit 7 low on driver fault
// - Bit 8 alternates each scan when healthy
// - Heartbeat freezes if any bit 4-7 low
// - Store and forward adds one sweep
// - Outputs one extra sweep, inputs two
// - Immediate update before logic saves input sweep
// - Baud rates 110 up to 57.6K
// - Parallel to serial out, serial to parallel in
// - Defaults 120 points, 57.6K, odd parity, halt
`timescale 1ns/1ps
`default_nettype none
module rio_driver #(
    parameter int CLK_HZ = rio_pkg::CLK_HZ // Clock rate behind the baud divisors
) (
    input  wire logic              ref_clk,    // System clock
    input  wire logic              rst_n,      // Async reset, active low
    rio_link_if.drv                link,       // Serial link to the remote receiver
    input  wire logic [6:0]        sw_in,      // Backplane switch segments 1-7
    input  wire rio_pkg::rio_cfg_t cfg_in,     // Option jumpers
    input  wire logic              scan_start, // Pulse at each I/O scan or immediate update
    input  wire logic [6:0]        io_addr,    // Byte reference, eight points each
    input  wire logic              io_wr,      // Output byte write strobe
    input  wire logic [7:0]        io_wdata,   // Output byte
    input  wire logic              io_rd,      // Input byte read strobe
    output logic      [7:0]        io_rdata,   // Input byte
    output logic                   io_ack,     // Access hit this block
    output logic      [7:0]        status,     // Copy of the status byte
    output logic                   cpu_halt    // Request to stop the CPU
);
    typedef struct packed {
        logic [6:0]                       sw1, sw2;
        rio_pkg::rio_cfg_t                cfg1, cfg2;
        logic                             up1, up2;
        logic [rio_pkg::MAX_BYTES-1:0][7:0] out_buf, tx_img, rx_img, in_buf;
        logic                             tx_busy;
        logic [10:0]                      tx_sh;
        logic [3:0]                       tx_bits;
        logic [rio_pkg::CNT_W-1:0]        tx_cnt;
        logic [5:0]                       tx_idx;
        logic                             tx_line;
        logic                             rx_busy;
        logic [10:0]                      rx_sh;
        logic [3:0]                       rx_bits;
        logic [rio_pkg::CNT_W-1:0]        rx_cnt;
        logic [5:0]                       rx_idx;
        logic [1:0]                       rx_rst;
        logic                             rx_done;
        logic                             waiting;
        logic [rio_pkg::CNT_W-1:0]        tk_cnt;
        logic [11:0]                      tmo;
        logic                             fresh, rpar, rok, link_ok, beat;
        logic [7:0]                       io_rdata, status;
        logic                             io_ack, halt;
    } rio_drv_st_t;

    rio_drv_st_t               r, n;
    logic [rio_pkg::CNT_W-1:0] div;
    logic [3:0]                nb;
    logic [5:0]                nby;
    logic [4:0]                off;
    logic                      hit, local_ok;
    logic [10:0]               v;
    logic [8:0]                dec;
    logic [7:0]                stat_byte;

    function automatic logic in_block(input logic [6:0] a, input logic [6:0] s, input logic m248);
        return m248 ? (a[6:5] == s[6:5]) : (a[6:4] == s[6:4]);
    endfunction

    always_comb begin
        n         = r;
        div       = rio_pkg::baud_div(CLK_HZ, r.cfg2.baud);
        nb        = rio_pkg::nbits(r.cfg2);
        nby       = rio_pkg::nbytes(r.cfg2);
        off       = r.cfg2.mode_248 ? io_addr[4:0] : {1'b0, io_addr[3:0]};
        hit       = in_block(io_addr, r.sw2, r.cfg2.mode_248) && (io_addr <= rio_pkg::GRP_LAST);
        local_ok  = (r.sw2 <= rio_pkg::GRP_LAST);
        v         = {r.up2, r.rx_sh[10:1]};
        dec       = rio_pkg::rx_decode(v, r.cfg2);
        stat_byte = 8'h00;
        stat_byte[rio_pkg::ST_FRESH] = r.fresh;
        stat_byte[rio_pkg::ST_RPAR]  = r.rpar;
        stat_byte[rio_pkg::ST_ROK]   = r.rok;
        stat_byte[rio_pkg::ST_LINK]  = r.link_ok;
        stat_byte[rio_pkg::ST_LOCAL] = local_ok;
        stat_byte[rio_pkg::ST_BEAT]  = r.beat;

        // Pins pass two flops; the sync copies also carry the default options through reset
        n.sw1  = sw_in;
        n.sw2  = r.sw1;
        n.cfg1 = cfg_in;
        n.cfg2 = r.cfg1;
        n.up1  = link.up;
        n.up2  = r.up1;

        n.io_ack = 1'b0;
        if ((io_rd || io_wr) && hit) begin
            n.io_ack = 1'b1;
            // status only at own unique reference
            if (io_addr == r.sw2) begin
                n.io_rdata = stat_byte;
            end else begin
                n.io_rdata = r.in_buf[off];
                if (io_wr) begin
                    n.out_buf[off] = io_wdata;
                end
            end
        end

        if (r.tk_cnt == '0) begin
            n.tk_cnt = div - 1'b1;
        end else begin
            n.tk_cnt = r.tk_cnt - 1'b1;
        end

        if (r.tx_busy) begin
            if (r.tx_cnt != '0) begin
                n.tx_cnt = r.tx_cnt - 1'b1;
            end else if (r.tx_bits == nb) begin
                if (r.tx_idx == nby) begin
                    n.tx_busy = 1'b0;
                    n.waiting = 1'b1;
                    n.tmo     = '0;
                    n.rx_idx  = '0;
                end else begin
                    n.tx_sh   = rio_pkg::tx_frame(r.tx_img[r.tx_idx[4:0]], r.cfg2);
                    n.tx_idx  = r.tx_idx + 1'b1;
                    n.tx_bits = '0;
                end
            end else begin
                n.tx_line = r.tx_sh[0];
                n.tx_sh   = {1'b1, r.tx_sh[10:1]};
                n.tx_bits = r.tx_bits + 1'b1;
                n.tx_cnt  = div - 1'b1;
            end
        end

        if (!r.rx_busy) begin
            if (!r.up2) begin
                n.rx_busy = 1'b1;
                n.rx_cnt  = div >> 1;
                n.rx_bits = '0;
            end
        end else if (r.rx_cnt != '0) begin
            n.rx_cnt = r.rx_cnt - 1'b1;
        end else if (r.rx_bits == '0 && r.up2) begin
            n.rx_busy = 1'b0;
        end else begin
            n.rx_sh   = v;
            n.rx_bits = r.rx_bits + 1'b1;
            n.rx_cnt  = div - 1'b1;
            if (r.rx_bits == nb - 1'b1) begin
                n.rx_busy = 1'b0;
                if (r.waiting) begin
                    if (!dec[8]) begin
                        n.waiting = 1'b0;
                        n.link_ok = 1'b0;
                    end else if (r.rx_idx == '0) begin
                        n.rx_rst = {dec[rio_pkg::RS_OK], dec[rio_pkg::RS_PAR]};
                        n.rx_idx = 6'h01;
                    end else begin
                        n.rx_img[5'(r.rx_idx - 1'b1)] = dec[7:0];
                        n.rx_idx = r.rx_idx + 1'b1;
                        if (r.rx_idx == nby) begin
                            // remote status taken with the frame
                            n.waiting = 1'b0;
                            n.rx_done = 1'b1;
                            n.link_ok = 1'b1;
                            n.rpar    = r.rx_rst[1'b0];
                            n.rok     = r.rx_rst[1'b1];
                        end
                    end
                end
            end
        end

        // silent receiver counts as link loss
        if (r.waiting && r.tk_cnt == '0) begin
            n.tmo = r.tmo + 1'b1;
            if (r.tmo == rio_pkg::TIMEOUT_BITS - 1'b1) begin
                n.waiting = 1'b0;
                n.link_ok = 1'b0;
                n.rok     = 1'b0;
            end
        end

        if (scan_start) begin
            // inputs handed over one sweep after arrival
            if (r.rx_done) begin
                n.in_buf  = r.rx_img;
                n.fresh   = ~r.fresh;
                n.rx_done = 1'b0;
            end
            if (r.rpar && r.rok && r.link_ok && local_ok) begin
                n.beat = ~r.beat;
            end
            // snapshot of outputs starts an exchange
            if (!r.tx_busy && !r.waiting) begin
                n.tx_img  = r.out_buf;
                n.tx_busy = 1'b1;
                n.tx_sh   = rio_pkg::tx_frame(rio_pkg::SYNC_BYTE, r.cfg2);
                n.tx_idx  = '0;
                n.tx_bits = '0;
                n.tx_cnt  = '0;
            end
        end

        n.status = stat_byte;
        n.halt   = (r.cfg2.halt_on_fail & ~r.link_ok) | (r.cfg2.halt_on_par & ~r.rpar);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            r         <= '0;
            // default options until the jumpers are seen
            r.cfg1    <= rio_pkg::CFG_DEF;
            r.cfg2    <= rio_pkg::CFG_DEF;
            r.up1     <= 1'b1;
            r.up2     <= 1'b1;
            r.tx_line <= 1'b1;
            r.rpar    <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign link.dn  = r.tx_line;
    assign io_rdata = r.io_rdata;
    assign io_ack   = r.io_ack;
    assign status   = r.status;
    assign cpu_halt = r.halt;
endmodule
`default_nettype wire

// ---- rtl/rio_receiver.sv ----
// Purpose: Remote-station end: unpacks output bytes, answers with station status and input bytes.
// Assumes: Station-side signals are on ref_clk; options must match the driver end.
// Notes:   A frame with any bad byte gets no answer, so the driver sees it as link loss.
`timescale 1ns/1ps
`default_nettype none
module rio_receiver #(
    parameter int CLK_HZ = rio_pkg::CLK_HZ // Clock rate behind the baud divisors
) (
    input  wire logic              ref_clk,    // System clock
    input  wire logic              rst_n,      // Async reset, active low
    rio_link_if.rcv                link,       // Serial link to the driver
    input  wire rio_pkg::rio_cfg_t cfg_in,     // Option jumpers
    output logic                   out_wr,     // Output byte strobe to station
    output logic      [4:0]        out_idx,    // Output byte index in block
    output logic      [7:0]        out_data,   // Output byte
    output logic      [4:0]        in_idx,     // Input byte index requested
    input  wire logic [7:0]        in_data,    // Input byte at in_idx
    input  wire logic              st_fault,   // Station supply or module fault
    input  wire logic              st_par_err, // Station parity error
    output logic                   out_kill,   // Force station outputs off
    output logic                   link_ok     // Link healthy
);
    typedef struct packed {
        rio_pkg::rio_cfg_t         cfg1, cfg2;
        logic                      dn1, dn2;
        logic                      rx_busy;
        logic [10:0]               rx_sh;
        logic [3:0]                rx_bits;
        logic [rio_pkg::CNT_W-1:0] rx_cnt;
        logic [5:0]                rx_idx;
        logic                      bad;
        logic                      tx_busy;
        logic [10:0]               tx_sh;
        logic [3:0]                tx_bits;
        logic [rio_pkg::CNT_W-1:0] tx_cnt;
        logic [5:0]                tx_idx;
        logic                      tx_line;
        logic [rio_pkg::CNT_W-1:0] tk_cnt;
        logic [11:0]               tmo;
        logic                      link_ok, kill, out_wr;
        logic [4:0]                out_idx, in_idx;
        logic [7:0]                out_data;
    } rio_rcv_st_t;

    rio_rcv_st_t               r, n;
    logic [rio_pkg::CNT_W-1:0] div;
    logic [3:0]                nb;
    logic [5:0]                nby;
    logic [10:0]               v;
    logic [8:0]                dec;
    logic [7:0]                rstat;

    always_comb begin
        n      = r;
        div    = rio_pkg::baud_div(CLK_HZ, r.cfg2.baud);
        nb     = rio_pkg::nbits(r.cfg2);
        nby    = rio_pkg::nbytes(r.cfg2);
        v      = {r.dn2, r.rx_sh[10:1]};
        dec    = rio_pkg::rx_decode(v, r.cfg2);
        rstat  = 8'h00;
        rstat[rio_pkg::RS_PAR] = ~st_par_err;
        rstat[rio_pkg::RS_OK]  = ~st_fault & ~st_par_err;
        n.cfg1   = cfg_in;
        n.cfg2   = r.cfg1;
        n.dn1    = link.dn;
        n.dn2    = r.dn1;
        n.out_wr = 1'b0;

        if (r.tk_cnt == '0) begin
            n.tk_cnt = div - 1'b1;
        end else begin
            n.tk_cnt = r.tk_cnt - 1'b1;
        end

        // frame in, bytes out to station
        if (!r.rx_busy) begin
            if (!r.dn2) begin
                n.rx_busy = 1'b1;
                n.rx_cnt  = div >> 1;
                n.rx_bits = '0;
            end
        end else if (r.rx_cnt != '0) begin
            n.rx_cnt = r.rx_cnt - 1'b1;
        end else if (r.rx_bits == '0 && r.dn2) begin
            n.rx_busy = 1'b0;
        end else begin
            n.rx_sh   = v;
            n.rx_bits = r.rx_bits + 1'b1;
            n.rx_cnt  = div - 1'b1;
            if (r.rx_bits == nb - 1'b1) begin
                n.rx_busy = 1'b0;
                if (r.rx_idx == '0) begin
                    if (dec[8] && dec[7:0] == rio_pkg::SYNC_BYTE) begin
                        n.rx_idx = 6'h01;
                        n.bad    = 1'b0;
                    end
                end else begin
                    n.rx_idx = r.rx_idx + 1'b1;
                    if (dec[8]) begin
                        n.out_wr   = 1'b1;
                        n.out_idx  = 5'(r.rx_idx - 1'b1);
                        n.out_data = dec[7:0];
                    end else begin
                        n.bad = 1'b1;
                    end
                    if (r.rx_idx == nby) begin
                        n.rx_idx = '0;
                        if (dec[8] && !r.bad && !r.tx_busy) begin
                            n.link_ok = 1'b1;
                            n.tmo     = '0;
                            n.tx_busy = 1'b1;
                            n.tx_sh   = rio_pkg::tx_frame(rstat, r.cfg2);
                            n.tx_idx  = '0;
                            n.tx_bits = '0;
                            n.tx_cnt  = '0;
                            n.in_idx  = '0;
                        end else begin
                            n.link_ok = 1'b0;
                        end
                    end
                end
            end
        end

        // answer: status byte, then input bytes
        if (r.tx_busy) begin
            if (r.tx_cnt != '0) begin
                n.tx_cnt = r.tx_cnt - 1'b1;
            end else if (r.tx_bits == nb) begin
                if (r.tx_idx == nby) begin
                    n.tx_busy = 1'b0;
                end else begin
                    n.tx_sh   = rio_pkg::tx_frame(in_data, r.cfg2);
                    n.in_idx  = 5'(r.tx_idx + 1'b1);
                    n.tx_idx  = r.tx_idx + 1'b1;
                    n.tx_bits = '0;
                end
            end else begin
                n.tx_line = r.tx_sh[0];
                n.tx_sh   = {1'b1, r.tx_sh[10:1]};
                n.tx_bits = r.tx_bits + 1'b1;
                n.tx_cnt  = div - 1'b1;
            end
        end

        // Silence on the line is a communication failure
        if (r.tk_cnt == '0 && r.tmo != rio_pkg::TIMEOUT_BITS) begin
            n.tmo = r.tmo + 1'b1;
            if (r.tmo == rio_pkg::TIMEOUT_BITS - 1'b1) begin
                n.link_ok = 1'b0;
            end
        end
        // outputs off on failure unless held
        n.kill = ~n.link_ok & ~r.cfg2.hold_last;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            r         <= '0;
            r.cfg1    <= rio_pkg::CFG_DEF;
            r.cfg2    <= rio_pkg::CFG_DEF;
            r.dn1     <= 1'b1;
            r.dn2     <= 1'b1;
            r.tx_line <= 1'b1;
            r.kill    <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign link.up  = r.tx_line;
    assign out_wr   = r.out_wr;
    assign out_idx  = r.out_idx;
    assign out_data = r.out_data;
    assign in_idx   = r.in_idx;
    assign out_kill = r.kill;
    assign link_ok  = r.link_ok;
endmodule
`default_nettype wire

// ---- verification/rio_link_sva.sv ----
// Purpose: Concurrent checks on the serial pair and the driver status byte.
// Assumes: 20 clocks per bit at the default baud rate.
// Notes:   Status trails the internal byte by one cycle.
`timescale 1ns/1ps
`default_nettype none
module rio_link_sva (
    input wire logic       ref_clk,    // Clock
    input wire logic       rst_n,      // Reset, low
    input wire logic       dn,         // Down line
    input wire logic       up,         // Up line
    input wire logic       scan_start, // Scan pulse
    input wire logic       io_rd,      // Read strobe
    input wire logic       io_wr,      // Write strobe
    input wire logic [6:0] io_addr,    // Reference
    input wire logic       io_ack,     // Hit
    input wire logic [7:0] status,     // Status byte
    input wire logic       cpu_halt    // Halt
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_idle_release: assert property ($rose(rst_n) |-> dn && up) else $error("Line busy"); // idle
    a_dn_bit: assert property ($fell(dn) |-> ##19 !dn) else $error("Short dn bit"); // bit time
    a_up_bit: assert property ($rose(up) |-> ##19 up) else $error("Short up bit"); // bit time
    a_ack_cause: assert property (io_ack |-> $past(io_rd || io_wr)) else $error("Stray ack"); // hit only
    a_top_refused: assert property ((io_rd || io_wr) && io_addr > 7'h7c |=> !io_ack) else $error("Ack high"); // cut
    a_reserved_zero: assert property (status[2:1] == 2'h0) else $error("Reserved set"); // reserved
    a_fresh_scan: assert property ($changed(status[0]) |-> $past(scan_start, 2)) else $error("Fresh"); // toggle
    // Heartbeat only moves on a scan with bits 4 to 7 good
    a_beat_healthy: assert property ($changed(status[7]) |-> $past(scan_start, 2) && $past(&status[6:3]))
        else $error("Heartbeat moved");
    a_halt_no_link: assert property ((!status[5])[*3] |-> cpu_halt) else $error("No halt"); // halt
    c_down_frame: cover property ($fell(dn));
    c_delivery: cover property ($changed(status[0]));
    c_read_hit: cover property (io_ack && $past(io_rd));
endmodule
`default_nettype wire

// ---- verification/remote_io_driver_status_tb.sv ----
// Purpose: Bench joining driver and receiver over the serial link.
// Assumes: CLK_HZ scaled so one bit is 20 clocks.
// Notes:   Station inputs echo their index, so replies are predictable.
`timescale 1ns/1ps
`default_nettype none
module remote_io_driver_status_tb;
    localparam int HZ = 1152000; // Short bit time keeps each exchange near 8k clocks
    logic          ref_clk = 1'b0;
    logic          rst_n, scan_start, io_rd, io_wr, io_ack, cpu_halt, out_wr, st_fault, st_par_err, out_kill;
    logic          ack_seen, rcv_ok;
    logic [6:0]    io_addr, sw;
    rio_pkg::rio_cfg_t cfg;
    logic [7:0]    io_wdata, io_rdata, status, out_data, in_data;
    logic [4:0]    out_idx, in_idx;
    logic [17:0]   rows [6];
    int            checks = 0, mismatches = 0;
    rio_link_if link ();
    assign in_data = {3'h5, in_idx};
    rio_driver #(.CLK_HZ(HZ)) i_rio_driver (.ref_clk, .rst_n, .link, .sw_in(sw), .cfg_in(cfg),
        .scan_start, .io_addr, .io_wr, .io_wdata, .io_rd, .io_rdata, .io_ack, .status, .cpu_halt);
    rio_receiver #(.CLK_HZ(HZ)) i_rio_receiver (.ref_clk, .rst_n, .link, .cfg_in(cfg), .out_wr,
        .out_idx, .out_data, .in_idx, .in_data, .st_fault, .st_par_err, .out_kill, .link_ok(rcv_ok));
    rio_link_sva i_rio_link_sva (.ref_clk, .rst_n, .dn(link.dn), .up(link.up), .scan_start, .io_rd, .io_wr,
        .io_addr, .io_ack, .status, .cpu_halt);
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic [1:0] rw, input logic [6:0] a, input logic [7:0] d);
        {io_rd, io_wr} = rw;
        io_addr = a;
        io_wdata = d;
        @(posedge ref_clk);
        #1 {io_rd, io_wr} = 2'b00;
        ack_seen = io_ack;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic sc();
        scan_start = 1'b1;
        @(posedge ref_clk);
        #1 scan_start = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask
    // Mode 2 sweeps every 2000 clocks while it waits, as a running CPU would
    task automatic wt(input int sel);
        int n;
        n = 0;
        while (!(sel == 0 ? out_wr === 1'b1 : sel == 1 ? status[5] === 1'b1 : status[3] === 1'b0)) begin
            scan_start = (sel == 2 && n % 2000 == 1);
            @(posedge ref_clk);
            #1 n++;
            if (n > 30000) begin
                mismatches++;
                summarize();
            end
        end
        scan_start = 1'b0;
    endtask
    initial begin
        {rst_n, scan_start, io_rd, io_wr, io_addr, io_wdata, st_fault, st_par_err} = '0;
        sw = 7'h12;
        cfg = rio_pkg::CFG_DEF;
        rows = '{{2'b01, 7'h10, 8'h3c, 1'b1}, {2'b01, 7'h1f, 8'hc3, 1'b1}, {2'b01, 7'h12, 8'hff, 1'b1},
                 {2'b01, 7'h20, 8'h55, 1'b0}, {2'b10, 7'h0f, 8'h00, 1'b0}, {2'b10, 7'h7d, 8'h00, 1'b0}};
        repeat (12) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        chk({6'h0, link.dn, link.up}, 8'h03); // idle high
        repeat (3) @(posedge ref_clk);
        #1 chk({6'h0, out_kill, cpu_halt}, 8'h03); // failsafe
        for (int i = 0; i < 6; i++) begin
            acc(rows[i][17:16], rows[i][15:9], rows[i][8:1]);
            chk({7'h0, ack_seen}, {7'h0, rows[i][0]}); // block hit
        end
        sc();
        wt(0);
        chk(out_data, 8'h3c); // first byte
        chk({3'h0, out_idx}, 8'h00); // byte offset
        wt(1);
        chk({6'h0, out_kill, rcv_ok}, 8'h01); // outputs live
        sc();
        acc(2'b10, 7'h11, 8'h00);
        chk(io_rdata, 8'ha1); // input byte
        acc(2'b10, 7'h1f, 8'h00);
        chk(io_rdata, 8'haf); // last byte
        acc(2'b10, 7'h12, 8'h00);
        chk(io_rdata, 8'hf9); // status read
        st_par_err = 1'b1;
        wt(2);
        repeat (2) @(posedge ref_clk);
        #1 chk({3'h0, cpu_halt, status[6:3]}, 8'h1c); // remote fault
        chk({7'h0, status[7]}, 8'h01); // four healthy sweeps
        sc();
        sc();
        chk({7'h0, status[7]}, 8'h01); // frozen beat
        cfg.mode_248 = 1'b1;
        sw = 7'h78;
        repeat (3) @(posedge ref_clk);
        #1 acc(2'b10, 7'h60, 8'h00);
        chk({6'h0, ack_seen, status[6]}, 8'h03); // wide block hit
        acc(2'b10, 7'h7d, 8'h00);
        chk({7'h0, ack_seen}, 8'h00); // truncated block
        sw = 7'h7e;
        repeat (4) @(posedge ref_clk);
        #1 chk({7'h0, status[6]}, 8'h00); // illegal own reference
        summarize();
    end
endmodule
`default_nettype wire
